// ---- hdl/mlc_counter_map.vh ----
// constants for the cascadable modified feedback shift counter
// assumes: included by the counter design file, no other dependency
`ifndef MLC_COUNTER_MAP_VH
`define MLC_COUNTER_MAP_VH

// width of one cascadable stage
`define MLC_STAGE_W 3
// width of the free-running variant
`define MLC_FOUR_W 4

// reset value of every stage register
`define MLC_STAGE_RESET 3'h0
// reset value of every carry register
`define MLC_CARRY_RESET 1'h0
// reset value of the free-running variant
`define MLC_FOUR_RESET 4'h0

// next-to-last state of a 3-bit stage
`define MLC_PENULT_STATE 3'h2
// last state of a 3-bit stage
`define MLC_FINAL_STATE 3'h4

// carry register delay in clock cycles
`define MLC_CARRY_DELAY 1

`endif

// ---- hdl/mlc_counter.v ----
// cascadable modified feedback shift counter: three 3-bit stages
// chained into a 9-bit counter, plus a free-running 4-bit variant
// assumes: one 40 MHz clock, synchronous active-high reset,
// countEnable comes from logic on the same clock
// no software-visible registers and no interrupt logic; the consumer of
// nineWrap or chainOutPermit sits on the same clock edge
`include "mlc_counter_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mlc_counter (
  // clock and reset
  input wire clk,
  input wire reset,
  // count qualifier of the first stage
  input wire countEnable,
  // stage states, bit zero least significant
  output wire [2:0] stageLowQ,
  output wire [2:0] stageMidQ,
  output wire [2:0] stageHighQ,
  // carry from the first stage and chain permits
  output wire carryLowQ,
  output wire midAdvance,
  output wire chainOutPermit,
  output wire nineWrap,
  // free-running 4-bit variant
  output wire [3:0] fourCountQ
);

  // low bit feedback of a 3-bit stage
  function lowBitNext;
    input [2:0] s;
    begin
      lowBitNext = (~s[1] & ~s[2])
        | (s[0] & ~s[2])
        | (~s[0] & s[1] & s[2]);
    end
  endfunction

  // one held-or-load bit: next = q & ~b | a & b
  function holdLoad;
    input q;
    input a;
    input b;
    begin
      holdLoad = (q & ~b) | (a & b);
    end
  endfunction

  // whole 3-bit stage step under one qualifier
  function [2:0] stageNext;
    input [2:0] s;
    input adv;
    begin
      // the same qualifier gates all three bits
      stageNext[0] = holdLoad(s[0], lowBitNext(s), adv);
      stageNext[1] = holdLoad(s[1], s[0], adv);
      stageNext[2] = holdLoad(s[2], s[1], adv);
    end
  endfunction

  // stage sits in its last state
  function isFinal;
    input [2:0] s;
    begin
      isFinal = (s == `MLC_FINAL_STATE);
    end
  endfunction

  // stage sits one step before its last state
  function isPenult;
    input [2:0] s;
    begin
      isPenult = (s == `MLC_PENULT_STATE);
    end
  endfunction

  // low bit feedback of the 4-bit variant
  function fourLowBit;
    input [3:0] s;
    begin
      case (s)
        // full table: every code has one successor, none is stuck
        4'h0: fourLowBit = 1'b1;
        4'h1: fourLowBit = 1'b1;
        4'h2: fourLowBit = 1'b0;
        4'h3: fourLowBit = 1'b1;
        4'h4: fourLowBit = 1'b0;
        4'h5: fourLowBit = 1'b1;
        4'h6: fourLowBit = 1'b0;
        4'h7: fourLowBit = 1'b1;
        4'h8: fourLowBit = 1'b0;
        4'h9: fourLowBit = 1'b0;
        4'ha: fourLowBit = 1'b1;
        4'hb: fourLowBit = 1'b0;
        4'hc: fourLowBit = 1'b1;
        4'hd: fourLowBit = 1'b0;
        4'he: fourLowBit = 1'b1;
        4'hf: fourLowBit = 1'b0;
        default: fourLowBit = 1'b0;
      endcase
    end
  endfunction

  // stage registers
  reg [2:0] lowQ;
  reg [2:0] lowD;
  reg [2:0] midQ;
  reg [2:0] midD;
  reg [2:0] highQ;
  reg [2:0] highD;

  // carry register of the first stage
  reg carry_q;
  reg carry_d;

  // free-running variant
  reg [3:0] four_q;
  reg [3:0] four_d;

  // advance qualifiers of the three stages
  wire lowAdv;
  wire midAdv;
  wire highAdv;

  // first stage counts under the external qualifier
  // a low qualifier freezes the whole chain: stages two and three only
  // ever move on an edge at which the first stage moves as well
  assign lowAdv = countEnable;

  // carry is only honoured while the first stage itself advances,
  // so a held first stage parked in its last state sends nothing
  assign midAdv = carry_q & countEnable;

  // propagate gate: combinational, no extra register delay
  // two AND gates sit between the carry register and the third stage,
  // so the third qualifier settles well inside one clock period
  assign highAdv = midAdv & isFinal(midQ);

  // first stage next state
  always @*
  begin
    lowD = stageNext(lowQ, lowAdv);
  end

  // second stage next state
  always @*
  begin
    midD = stageNext(midQ, midAdv);
  end

  // third stage next state
  always @*
  begin
    highD = stageNext(highQ, highAdv);
  end

  // decode the next-to-last state one clock early
  // the carry is launched from a flip-flop, so the next stage does not
  // wait for a decode of the last state to ripple through gates;
  // a held stage keeps its carry so a parked last state stays marked
  always @*
  begin
    if (lowAdv)
    begin
      carry_d = isPenult(lowQ);
    end
    else
    begin
      carry_d = carry_q;
    end
  end

  // free-running variant: low bit from logic, upper bits shift
  // it has no qualifier and runs on every edge out of reset
  always @*
  begin
    four_d = {four_q[2:0], fourLowBit(four_q)};
  end

  // first stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      lowQ <= `MLC_STAGE_RESET;
    end
    else
    begin
      lowQ <= lowD;
    end
  end

  // second stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      midQ <= `MLC_STAGE_RESET;
    end
    else
    begin
      midQ <= midD;
    end
  end

  // third stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      highQ <= `MLC_STAGE_RESET;
    end
    else
    begin
      highQ <= highD;
    end
  end

  // carry register
  always @(posedge clk)
  begin
    if (reset)
    begin
      carry_q <= `MLC_CARRY_RESET;
    end
    else
    begin
      carry_q <= carry_d;
    end
  end

  // free-running variant register
  always @(posedge clk)
  begin
    if (reset)
    begin
      four_q <= `MLC_FOUR_RESET;
    end
    else
    begin
      four_q <= four_d;
    end
  end

  // outputs
  assign stageLowQ = lowQ;
  assign stageMidQ = midQ;
  assign stageHighQ = highQ;
  assign carryLowQ = carry_q;
  assign midAdvance = midAdv;
  assign chainOutPermit = highAdv;

  // whole 9-bit counter wraps on the coming edge
  // one pulse per 512 advances, usable as a pass marker downstream
  assign nineWrap = highAdv & isFinal(highQ);

  assign fourCountQ = four_q;

endmodule // mlc_counter

`default_nettype wire

// ---- tb/mlc_counter_props.sv ----
// checker for the cascaded feedback shift counter ports
// assumes: bound into mlc_counter, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module mlc_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // qualifier and stage states
  input wire logic countEnable,
  input wire logic [2:0] stageLowQ,
  input wire logic [2:0] stageMidQ,
  input wire logic [2:0] stageHighQ,
  // carry and chain
  input wire logic carryLowQ,
  input wire logic midAdvance,
  input wire logic chainOutPermit,
  input wire logic nineWrap,
  // free-running variant
  input wire logic [3:0] fourCountQ
);
  wire logic [2:0] s = stageLowQ;
  wire logic lowNext = (~s[1] & ~s[2]) | (s[0] & ~s[2])
    | (~s[0] & s[1] & s[2]);
  wire logic isTwo = (s == 3'h2);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_hold;
    !countEnable |=> $stable(stageLowQ) && $stable(carryLowQ);
  endproperty
  a_hold: assert property (p_hold) else $error("held stage moved");
  property p_shift;
    countEnable |=> stageLowQ[2:1] == $past(stageLowQ[1:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("no shift");
  property p_low;
    countEnable |=> stageLowQ[0] == $past(lowNext);
  endproperty
  a_low: assert property (p_low) else $error("low bit wrong");
  property p_carry;
    countEnable |=> carryLowQ == $past(isTwo);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_mid;
    midAdvance |-> carryLowQ && stageLowQ == 3'h4;
  endproperty
  a_mid: assert property (p_mid) else $error("early advance");
  property p_prop;
    chainOutPermit == (midAdvance && stageMidQ == 3'h4);
  endproperty
  a_prop: assert property (p_prop) else $error("bad permit");
  property p_wrap;
    nineWrap |=> {stageHighQ, stageMidQ, stageLowQ} == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_four;
    1'b1 |=> fourCountQ[3:1] == $past(fourCountQ[2:0]);
  endproperty
  a_four: assert property (p_four) else $error("four no shift");
  c_wrap: cover property (nineWrap);
  c_held: cover property (!countEnable && carryLowQ);
  c_chain: cover property (chainOutPermit);
endmodule // mlc_props
bind mlc_counter mlc_props u_props (.clk, .reset, .countEnable, .stageLowQ,
  .stageMidQ, .stageHighQ, .carryLowQ, .midAdvance, .chainOutPermit,
  .nineWrap, .fourCountQ);
`default_nettype wire

// ---- tb/mlc_sink.sv ----
// consumer of the 9-bit wrap, counts refresh passes
// assumes: same clock and reset as the counter
`timescale 1ns/1ps
`default_nettype none
module mlc_sink (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wrap qualifier and pass count
  input wire logic nineWrap,
  output var logic [7:0] wrapsQ
);
  always @(posedge clk)
  begin
    if (reset)
      wrapsQ <= 8'h00;
    else if (nineWrap)
      wrapsQ <= wrapsQ + 8'h01;
  end
endmodule // mlc_sink
`default_nettype wire

// ---- tb/mlc_counter_tb.sv ----
// self-checking bench for the cascaded feedback shift counter
// assumes: design and sink compiled first
`timescale 1ns/1ps
`default_nettype none
module mlc_counter_tb;
  logic clk = 1'b0, reset = 1'b1, countEnable = 1'b0;
  wire [2:0] stageLowQ, stageMidQ, stageHighQ;
  wire carryLowQ, midAdvance, chainOutPermit, nineWrap;
  wire [3:0] fourCountQ;
  wire logic [7:0] wrapsQ;
  int n_fail = 0, checks_done = 0, cyc = 0;
  // {carry, stage one, four-bit} per enabled step
  logic [7:0] rows [16] = '{8'h00, 8'h11, 8'h33, 8'h77, 8'h6f, 8'h5e,
    8'h2d, 8'hca, 8'h05, 8'h1b, 8'h36, 8'h7c, 8'h69, 8'h52, 8'h24, 8'hc8};
  always #12.5 clk = ~clk;
  mlc_counter dut (.clk(clk), .reset(reset), .countEnable(countEnable),
    .stageLowQ(stageLowQ), .stageMidQ(stageMidQ), .stageHighQ(stageHighQ),
    .carryLowQ(carryLowQ), .midAdvance(midAdvance),
    .chainOutPermit(chainOutPermit), .nineWrap(nineWrap),
    .fourCountQ(fourCountQ));
  mlc_sink sink (.clk(clk), .reset(reset), .nineWrap(nineWrap),
    .wrapsQ(wrapsQ));
  task automatic cmp(input string nm, input logic [15:0] exp, got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task automatic stop_test;
  begin
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      stop_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    countEnable <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      cmp("row", rows[i], {carryLowQ, stageLowQ, fourCountQ});
    end
    repeat (8) @(posedge clk);
    countEnable <= 1'b0;
    repeat (3) @(negedge clk);
    cmp("held", 16'h00c6, {carryLowQ, stageLowQ, stageMidQ, midAdvance});
    @(posedge clk);
    countEnable <= 1'b1;
    repeat (489) @(posedge clk);
    countEnable <= 1'b0;
    @(negedge clk);
    cmp("wrap", 16'h0200, {wrapsQ[6:0], stageHighQ, stageMidQ, stageLowQ});
    @(posedge clk);
    countEnable <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp("rst", 16'h0000, {fourCountQ, carryLowQ, stageHighQ, stageMidQ,
      stageLowQ});
    stop_test;
  end
endmodule // mlc_counter_tb
`default_nettype wire
